//--- core/mgmt_mode_ctl.sv
// Behaviour
// RULE1 - mode entry blocks all incoming NMI requests
// RULE2 - IF set plus taken maskable request unblocks NMI
// RULE3 - trap or fault exception in mode unblocks NMI
// RULE4 - system releases mask around save and restore
// RULE5 - system suppresses mask while mode active
// RULE6 - mask released one I/O clock before active
// RULE7 - state save starts with active, no delay; not met when mem_ack or gap_r is high in the entry cycle
// RULE8 - late mask release may hit first saves
// RULE9 - system may hold request until mask released
// RULE10 - save memory should avoid odd megabyte ranges
// RULE11 - recognised mask forces address bit 20 low
`timescale 1ns/1ps
`include "mgmt_cfg.svh"

module mgmt_mode_ctl
  import mgmt_pkg::*;
#(
  parameter logic [31:0] SAVE_BASE = `SAVE_BASE_DEF,
  parameter int SAVE_WORDS = `SAVE_WORDS_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mgmt_interrupt_request,
  input wire logic nmi_request,
  input wire logic maskable_interrupt_request,
  input wire logic address_bit20_mask_in,
  input wire logic if_flag,
  input wire logic exception_taken,
  input wire logic resume_req,
  input wire logic core_req,
  input wire logic core_write,
  input wire logic [31:0] core_addr,
  input wire logic mem_ack,
  output logic mgmt_mode_active_out,
  output logic nmi_take,
  output logic maskable_take,
  output logic nmi_blocked,
  output logic mem_valid,
  output logic mem_write,
  output logic [31:0] mem_addr
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [`PIN_COUNT-1:0] pin_in;
  wire [`PIN_COUNT-1:0] pin_s;
  logic nmi_d_r;

  assign pin_in[`PIN_REQ] = mgmt_interrupt_request;
  assign pin_in[`PIN_NMI] = nmi_request;
  assign pin_in[`PIN_MIRQ] = maskable_interrupt_request;
  assign pin_in[`PIN_A20] = address_bit20_mask_in;

  // one two-flop chain per pin; only the second flop is ever read
  for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_sync
    logic meta_r;
    logic sync_r;

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
      end else if (ce) begin
        meta_r <= pin_in[g];
        sync_r <= meta_r;
      end
    end
    assign pin_s[g] = sync_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nmi_d_r <= 1'b0;
    end else if (ce) begin
      nmi_d_r <= pin_s[`PIN_NMI];
    end
  end

  wire req_s = pin_s[`PIN_REQ];
  wire mirq_s = pin_s[`PIN_MIRQ];
  // two flops of latency: a mask dropped late is still seen on early saves [RULE8]
  wire a20_s = pin_s[`PIN_A20];
  wire nmi_edge = pin_s[`PIN_NMI] & ~nmi_d_r;

  // ****************************************************************
  // mode sequencing
  // ****************************************************************
  save_bus_if sbus ();

  save_seq #(
    .BASE(SAVE_BASE),
    .WORDS(SAVE_WORDS)
  ) u_seq (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .bus(sbus)
  );

  // phases in which the sequencer owns the memory path
  function automatic logic seq_state(mm_state_t s);
    return (s == MM_SAVE) | (s == MM_RESTORE);
  endfunction : seq_state

  mm_state_t state_r;
  mm_state_t state_nxt;

  // the system is trusted to gate the request and mask pins [RULE9]
  wire entry_accept = (state_r == MM_IDLE) & req_s;
  wire resume_go = (state_r == MM_HANDLER) & resume_req;
  wire in_mode = (state_r != MM_IDLE);
  wire seq_phase = seq_state(state_r);
  wire seq_owns = seq_phase | sbus.start;

  assign sbus.start = entry_accept | resume_go;
  assign sbus.restore = resume_go;
  assign sbus.cycle_ack = mem_ack & seq_owns;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MM_IDLE: begin
        if (entry_accept) begin
          state_nxt = MM_SAVE;
        end
      end
      MM_SAVE: begin
        if (sbus.done) begin
          state_nxt = MM_HANDLER;
        end
      end
      MM_HANDLER: begin
        if (resume_go) begin
          state_nxt = MM_RESTORE;
        end
      end
      MM_RESTORE: begin
        if (sbus.done) begin
          state_nxt = MM_IDLE;
        end
      end
      default: begin
        state_nxt = MM_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // interrupt gating
  // ****************************************************************
  logic nmi_pend_r;
  logic blocked_r;

  // a taken maskable request only counts once software has set IF [RULE2]
  wire mirq_go = mirq_s & if_flag & ~maskable_take;
  wire nmi_go = nmi_pend_r & ~blocked_r;
  // outside the mode neither path touches the block
  wire unblock = in_mode & (mirq_go | exception_taken); // [RULE2] [RULE3]
  // leaving the mode reopens nmi as well, so nothing stays blocked for good
  wire exit_done = (state_r == MM_RESTORE) & sbus.done;
  // entry wins over a same-cycle unblock
  wire blocked_nxt = entry_accept | (blocked_r & ~unblock & ~exit_done); // [RULE1]
  // a new edge in the take cycle stays pending
  wire nmi_pend_nxt = nmi_edge | (nmi_pend_r & ~nmi_go);

  // ****************************************************************
  // external memory path
  // ****************************************************************
  // only bit 20 is touched; the rest of the address passes as issued
  function automatic logic [31:0] fold_bit20(logic [31:0] a, logic en);
    return en ? (a & ~(32'h0000_0001 << `A20_BIT)) : a;
  endfunction : fold_bit20

  wire [31:0] raw_addr = seq_owns ? sbus.cycle_addr : core_addr;
  // system keeps the mask off around save and restore [RULE4] [RULE5] [RULE6]
  wire [31:0] addr_nxt = fold_bit20(raw_addr, a20_s); // [RULE11]
  // dropped on ack so the same request is never presented twice
  wire valid_nxt = (seq_owns ? sbus.cycle_valid : core_req) & ~mem_ack;
  wire write_nxt = seq_owns ? sbus.cycle_write : core_write;

  // ****************************************************************
  // output registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= MM_IDLE;
      blocked_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      mgmt_mode_active_out <= 1'b0;
      nmi_take <= 1'b0;
      maskable_take <= 1'b0;
      nmi_blocked <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      blocked_r <= blocked_nxt; // [RULE1]
      nmi_pend_r <= nmi_pend_nxt;
      mgmt_mode_active_out <= (state_nxt != MM_IDLE);
      nmi_take <= nmi_go;
      maskable_take <= mirq_go;
      nmi_blocked <= blocked_nxt;
    end
  end

  // memory cycle registers kept apart from the mode flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= '0;
    end else if (ce) begin
      // first save word leaves on the same edge as the active output unless mem_ack or gap_r is high in the entry cycle [RULE7]
      mem_valid <= valid_nxt;
      mem_write <= write_nxt;
      mem_addr <= addr_nxt;
    end
  end

endmodule : mgmt_mode_ctl

//--- core/save_seq.sv
`timescale 1ns/1ps
`include "mgmt_cfg.svh"

module save_seq
  import mgmt_pkg::*;
#(
  parameter logic [31:0] BASE = `SAVE_BASE_DEF,
  parameter int WORDS = `SAVE_WORDS_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  save_bus_if.seq bus
);

  localparam int IW = $clog2(WORDS + 1);

  logic busy_r;
  logic gap_r;
  logic wr_r;
  logic [IW-1:0] idx_r;

  wire last = (idx_r == IW'(WORDS - 1));
  wire take = bus.cycle_valid & bus.cycle_ack;

  // valid already in the start cycle unless gap_r is set, so the first word leaves with no delay
  assign bus.cycle_valid = (busy_r | bus.start) & ~gap_r;
  assign bus.cycle_write = bus.start ? ~bus.restore : wr_r;
  assign bus.cycle_addr = BASE + (32'(idx_r) * `WORD_BYTES);
  assign bus.done = take & last;

  // one idle cycle after each ack keeps a stale request from being acked twice
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      gap_r <= 1'b0;
      wr_r <= 1'b0;
      idx_r <= '0;
    end else if (ce) begin
      gap_r <= take;
      if (bus.start) begin
        busy_r <= 1'b1;
        wr_r <= ~bus.restore;
      end
      if (take) begin
        busy_r <= ~last;
        idx_r <= last ? '0 : idx_r + 1'b1;
      end
    end
  end

endmodule : save_seq

//--- shared/mgmt_cfg.svh
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH

// ****************************************************************
// save area layout
// ****************************************************************
`define SAVE_BASE_DEF 32'h0003_0000
`define SAVE_WORDS_DEF 8
`define WORD_BYTES 32'h0000_0004

// ****************************************************************
// address masking and pin synchroniser
// ****************************************************************
`define A20_BIT 20
`define PIN_COUNT 4
`define PIN_REQ 0
`define PIN_NMI 1
`define PIN_MIRQ 2
`define PIN_A20 3

`endif

//--- shared/mgmt_pkg.sv
package mgmt_pkg;

  // gray order along entry, handler, exit
  typedef enum logic [1:0] {
    MM_IDLE = 2'h0,
    MM_SAVE = 2'h1,
    MM_HANDLER = 2'h3,
    MM_RESTORE = 2'h2
  } mm_state_t;

endpackage : mgmt_pkg

//--- shared/save_bus_if.sv
`timescale 1ns/1ps

interface save_bus_if;
  logic start;
  logic restore;
  logic cycle_valid;
  logic cycle_write;
  logic [31:0] cycle_addr;
  logic cycle_ack;
  logic done;

  modport seq (
    input start,
    input restore,
    input cycle_ack,
    output cycle_valid,
    output cycle_write,
    output cycle_addr,
    output done
  );

  modport ctl (
    output start,
    output restore,
    output cycle_ack,
    input cycle_valid,
    input cycle_write,
    input cycle_addr,
    input done
  );
endinterface : save_bus_if

//--- tb/chipset_model.sv
`timescale 1ns/1ps
module chipset_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_want,
  input wire logic mask_want,
  input wire logic stall,
  input wire logic active,
  input wire logic mem_valid,
  output logic req_r,
  output logic mask_r,
  output logic ack_r
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {req_r, mask_r, ack_r} <= 3'h0;
    end else begin
      mask_r <= mask_want & ~req_want & ~active;
      // request waits a cycle behind the mask release
      req_r <= req_want & ~mask_r;
      ack_r <= mem_valid & ~ack_r & ~stall;
    end
  end
endmodule : chipset_model

//--- tb/mgmt_checker.sv
`timescale 1ns/1ps
module mgmt_checker #(
  parameter logic [31:0] SAVE_BASE = 32'h0003_0000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic if_flag,
  input wire logic exception_taken,
  input wire logic address_bit20_mask_in,
  input wire logic mgmt_mode_active_out,
  input wire logic nmi_take,
  input wire logic maskable_take,
  input wire logic nmi_blocked,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr
);
  wire act = mgmt_mode_active_out;
  wire msk = address_bit20_mask_in;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence save_first;
    mem_valid && mem_write && mem_addr == SAVE_BASE;
  endsequence
  a_entry_blocks: assert property ($rose(act) |-> nmi_blocked)
    else $error("entry left nmi open");
  a_block_holds: assert property (nmi_blocked && $past(nmi_blocked) |-> !nmi_take)
    else $error("nmi taken while blocked");
  a_mirq_unblocks: assert property (maskable_take && act && $past(act) |-> !nmi_blocked)
    else $error("maskable take left nmi blocked");
  a_mirq_gated: assert property (maskable_take |-> $past(if_flag))
    else $error("maskable take with flag clear");
  a_exc_unblocks: assert property (exception_taken && act |=> !nmi_blocked)
    else $error("exception left nmi blocked");
  a_save_start: assert property ($rose(act) |-> save_first)
    else $error("save not started with active");
  a_exit_unblocks: assert property ($fell(act) |-> !nmi_blocked)
    else $error("exit left nmi blocked");
  // late release is tolerated: only a mask seen for four edges must clear the bit
  a_mask_addr: assert property ($rose(mem_valid) && $past(msk) && $past(msk, 2)
    && $past(msk, 3) && $past(msk, 4) |-> !mem_addr[20]) else $error("bit 20 not masked");
endmodule : mgmt_checker
bind mgmt_mode_ctl mgmt_checker #(.SAVE_BASE(SAVE_BASE)) chk_u (.*);

//--- tb/mgmt_mode_entry_interrupt_gating_test.sv
`timescale 1ns/1ps
module mgmt_mode_entry_interrupt_gating_test;
  import mgmt_pkg::*;
  // odd megabyte base shows the mask really released around save and restore
  localparam logic [31:0] BASE = 32'h0030_0000;
  logic mclk = 0, rst = 1, nmi = 0, mirq = 0, ifl = 0, exc = 0, res = 0;
  logic creq = 0, cwr = 0, smw = 0, mkw = 0, stall = 0;
  logic [31:0] cad = 0, seed = 32'he31493d4;
  wire mreq, msk, ack, act, nt, it, blk, mv, mw;
  wire [31:0] ma;
  logic [32:0] expq[$];
  int err_total = 0, total_checks = 0, nts = 0, its = 0;
  mgmt_mode_ctl #(.SAVE_BASE(BASE), .SAVE_WORDS(2)) dut_u (.mclk, .rst, .ce(1'b1),
    .mgmt_interrupt_request(mreq), .nmi_request(nmi), .maskable_interrupt_request(mirq),
    .address_bit20_mask_in(msk), .if_flag(ifl), .exception_taken(exc), .resume_req(res),
    .core_req(creq), .core_write(cwr), .core_addr(cad), .mem_ack(ack),
    .mgmt_mode_active_out(act), .nmi_take(nt), .maskable_take(it), .nmi_blocked(blk),
    .mem_valid(mv), .mem_write(mw), .mem_addr(ma));
  chipset_model pm_u (.mclk, .rst, .req_want(smw), .mask_want(mkw), .stall, .active(act),
    .mem_valid(mv), .req_r(mreq), .mask_r(msk), .ack_r(ack));
  initial forever #4 mclk = ~mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(string nm, logic [32:0] s, logic [32:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic drain();
    for (int k = 0; k < 99 && expq.size() > 0; k++) @(posedge mclk);
    #1 chk("left", expq.size(), 0);
  endtask : drain
  always @(posedge mclk) begin
    stall <= xs() > 32'h9fff_ffff;
    nts += (nt === 1'b1);
    its += (it === 1'b1);
    if (mv === 1'b1 && ack === 1'b1)
      chk("mem", {mw, ma}, expq.size() ? expq.pop_front() : 33'h0);
  end
  task automatic mode(int kind);
    for (int i = 0; i < 2; i++) expq.push_back({1'b1, BASE + 32'h4 * i});
    @(posedge mclk) smw <= 1;
    mkw <= 1;
    for (int k = 0; k < 20 && act !== 1'b1; k++) @(posedge mclk);
    @(posedge mclk) nmi <= 1;
    smw <= 0;
    drain();
    repeat (4) @(posedge mclk);
    #1 chk("blk", blk, 1);
    chk("nmi", nts, kind);
    if (kind == 0) begin
      @(posedge mclk) mirq <= 1;
      repeat (6) @(posedge mclk);
      #1 chk("mirq", its, 0);
      @(posedge mclk) ifl <= 1;
      for (int k = 0; k < 20 && its == 0; k++) @(posedge mclk);
    end else begin
      @(posedge mclk) exc <= 1;
      @(posedge mclk) exc <= 0;
    end
    repeat (4) @(posedge mclk);
    #1 chk("nmi", nts, kind + 1);
    for (int i = 0; i < 2; i++) expq.push_back({1'b0, BASE + 32'h4 * i});
    @(posedge mclk) res <= 1;
    {nmi, mirq, ifl} <= 3'h0;
    @(posedge mclk) res <= 0;
    drain();
    repeat (3) @(posedge mclk);
    #1 chk("act", act, 0);
  endtask : mode
  initial begin
    logic [31:0] r;
    repeat (8) @(posedge mclk);
    rst <= 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk) mkw <= i[0];
      repeat (6) @(posedge mclk);
      r = xs();
      cad <= r;
      cwr <= i[1];
      creq <= 1;
      expq.push_back({i[1], i[0] ? r & 32'hffef_ffff : r});
      for (int k = 0; k < 99 && ack !== 1'b1; k++) begin
        @(posedge mclk);
        #1;
      end
      @(posedge mclk) creq <= 0;
    end
    drain();
    mode(0);
    mode(1);
    print_verdict();
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule : mgmt_mode_entry_interrupt_gating_test
